// ### src/i2c_slave_pkg.sv
// Constants, reset values and state encoding shared by the serial-port slave logic
`default_nettype none
package i2c_slave_pkg;
  // Bits per byte on the wire; the ninth clock carries the acknowledge
  localparam logic [3:0] BYTE_BITS     = 4'h8;
  localparam logic [3:0] LAST_TX_FALL  = 4'h7;
  // Leading pattern of a 10-bit high address byte
  localparam logic [4:0] HI_ADDR_PATTERN = 5'h1E;
  // Field positions inside the address byte
  localparam int unsigned HI_PAT_MSB   = 7;
  localparam int unsigned HI_PAT_LSB   = 3;
  localparam int unsigned UPPER_A_MSB  = 2;
  localparam int unsigned UPPER_A_LSB  = 1;
  localparam int unsigned RW_BIT       = 0;
  // Reset values and the constant line drive level
  localparam logic [7:0] ADDR_RESET    = 8'h00;
  localparam logic [7:0] BUF_RESET     = 8'h00;
  localparam logic       CKP_RESET     = 1'b1;
  localparam logic       LINE_LOW      = 1'b0;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ADDR   = 3'b001,
    ST_HOLD   = 3'b010,
    ST_ACK    = 3'b011,
    ST_TX     = 3'b100,
    ST_TX_ACK = 3'b101,
    ST_RX     = 3'b110,
    ST_RX_ACK = 3'b111
  } slave_state_e;
endpackage
`default_nettype wire

// ### src/line_if.sv
// Synchronised bus line levels and conditions passed to the slave control logic
`default_nettype none
interface line_if;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  modport sync_side (output scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det);
  modport ctrl_side (input  scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det);
endinterface
`default_nettype wire

// ### src/line_sync.sv
// Two-stage synchronisers on the bus lines with edge, Start and Stop detection
`default_nettype none
module line_sync (
  input  wire logic       core_clk,   // System clock
  input  wire logic       rst_n,      // Synchronous reset, active low
  input  wire logic       scl_in,     // Clock line level from the pin
  input  wire logic       sda_in,     // Data line level from the pin
  line_if.sync_side       line        // Conditions toward the controller
);
  logic [1:0] pin_raw;
  logic [1:0] meta_q;
  logic [1:0] meta_d;
  logic [1:0] sync_q;
  logic [1:0] sync_d;
  logic [1:0] prev_q;
  logic [1:0] prev_d;

  assign pin_raw = {sda_in, scl_in};

  // Both lines get the same three flops; only the second and third stages are ever looked at
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_line
      always_comb
      begin
        meta_d[gi] = pin_raw[gi];
        sync_d[gi] = meta_q[gi];
        prev_d[gi] = sync_q[gi];
      end
    end
  endgenerate

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      meta_q <= 2'h3;
      sync_q <= 2'h3;
      prev_q <= 2'h3;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  // Start is SDA falling while SCL stays high; Stop is SDA rising while SCL stays high
  assign line.scl_s     = sync_q[0];
  assign line.sda_s     = sync_q[1];
  assign line.scl_rise  = sync_q[0] & ~prev_q[0];
  assign line.scl_fall  = ~sync_q[0] & prev_q[0];
  assign line.start_det = sync_q[0] & prev_q[0] & prev_q[1] & ~sync_q[1];
  assign line.stop_det  = sync_q[0] & prev_q[0] & ~prev_q[1] & sync_q[1];
endmodule
`default_nettype wire

// ### src/i2c_slave.sv
// Serial-port slave: read transfers, address hold and 10-bit address reception
`default_nettype none
module i2c_slave (
  input  wire logic       core_clk,          // System clock, 50 MHz
  input  wire logic       rst_n,             // Synchronous reset, active low
  input  wire logic       scl_in,            // Clock line level
  output logic            scl_out,           // Clock line drive value, always low
  output logic            scl_oe_n,          // Clock line pulled low while this is low
  input  wire logic       sda_in,            // Data line level
  output logic            sda_out,           // Data line drive value, always low
  output logic            sda_oe_n,          // Data line pulled low while this is low
  input  wire logic       ten_bit_mode,      // 10-bit addressing
  input  wire logic       address_hold_en,   // Firmware decides the address acknowledge
  input  wire logic       stretch_enable,    // Stretch after each received byte
  input  wire logic       slave_collision_detect_en, // Collision detect while sending
  input  wire logic       start_irq_en,      // Start condition raises the interrupt flag
  input  wire logic       ack_data_bit,      // Ack value chosen in hold, 1 = not-ack
  input  wire logic       addr_wr,           // Pulse: write address register
  input  wire logic [7:0] addr_wdata,        // Address register write data
  input  wire logic       data_wr,           // Pulse: write data buffer
  input  wire logic [7:0] data_wdata,        // Data buffer write data
  input  wire logic       data_rd,           // Pulse: buffer read, clears buffer full
  input  wire logic       clock_release_set, // Pulse: set the clock release bit
  input  wire logic       irq_clear,         // Pulse: clear the port interrupt flag
  input  wire logic       collision_clear,   // Pulse: clear the collision flag
  output logic [7:0]      slave_address_reg, // Address register
  output logic [7:0]      port_data_buffer,  // Data buffer
  output logic            read_write_flag,   // Last matched address asked for a read
  output logic            start_flag,        // Start seen last
  output logic            stop_flag,         // Stop seen last
  output logic            ack_status_bit,    // Master response, 1 = not-ack
  output logic            ack_time_flag,     // Inside an address hold acknowledge time
  output logic            port_interrupt_flag, // Sticky event flag
  output logic            bus_collision_flag,  // Sticky collision flag
  output logic            buffer_full_flag,  // Buffer written or received into since the last read pulse
  output logic            update_address_flag, // 10-bit address register update due
  output logic            clock_release_bit  // Clock released when high and no address update is due
);
  import i2c_slave_pkg::*;

  line_if line ();

  line_sync u_line_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .scl_in   (scl_in),
    .sda_in   (sda_in),
    .line     (line.sync_side)
  );

  slave_state_e state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] rx_shift_q, rx_shift_d;
  logic [7:0] tx_shift_q, tx_shift_d;
  logic [7:0] addr_q, addr_d;
  logic [7:0] buf_q, buf_d;
  logic       rw_q, rw_d;
  logic       start_q, start_d;
  logic       stop_q, stop_d;
  logic       ackst_q, ackst_d;
  logic       ack_time_flag_q, ack_time_flag_d;
  logic       irq_q, irq_d;
  logic       bcl_q, bcl_d;
  logic       bf_q, bf_d;
  logic       ua_q, ua_d;
  logic       ckp_q, ckp_d;
  logic       nack_q, nack_d;
  logic       lo_byte_q, lo_byte_d;
  logic       addr10_ok_q, addr10_ok_d;
  logic       hold_q, hold_d;
  logic       sda_n_q, sda_n_d;
  logic       addr_match;
  logic       hi_match;
  logic       byte_done;

  // Address compare on the byte just shifted in
  always_comb
  begin
    hi_match = (rx_shift_q[HI_PAT_MSB:HI_PAT_LSB] == HI_ADDR_PATTERN) &&
               (rx_shift_q[UPPER_A_MSB:UPPER_A_LSB] == addr_q[UPPER_A_MSB:UPPER_A_LSB]);
    if (!ten_bit_mode)
      addr_match = (rx_shift_q[7:1] == addr_q[7:1]);
    else if (lo_byte_q)
      addr_match = (rx_shift_q == addr_q);
    else
      addr_match = hi_match && (!rx_shift_q[RW_BIT] || addr10_ok_q); // Reads only after a full match
  end

  assign byte_done = line.scl_fall && (cnt_q == BYTE_BITS);

  // Next-state and register updates; firmware actions first so bus events override them
  always_comb
  begin
    state_d     = state_q;
    cnt_d       = cnt_q;
    rx_shift_d  = rx_shift_q;
    tx_shift_d  = tx_shift_q;
    addr_d      = addr_q;
    buf_d       = buf_q;
    rw_d        = rw_q;
    start_d     = start_q;
    stop_d      = stop_q;
    ackst_d     = ackst_q;
    ack_time_flag_d    = ack_time_flag_q;
    bcl_d       = bcl_q && !collision_clear;
    irq_d       = irq_q && !irq_clear;
    bf_d        = bf_q && !data_rd;
    ua_d        = ua_q;
    ckp_d       = ckp_q || clock_release_set;
    nack_d      = nack_q;
    lo_byte_d   = lo_byte_q;
    addr10_ok_d = addr10_ok_q;
    if (addr_wr)
    begin
      addr_d = addr_wdata;
      ua_d   = 1'b0;
    end
    if (data_wr)
    begin
      buf_d      = data_wdata;
      tx_shift_d = data_wdata;
      bf_d       = 1'b1;
    end
    case (state_q)
      ST_ADDR:
      begin
        if (line.scl_rise && cnt_q != BYTE_BITS)
        begin
          rx_shift_d = {rx_shift_q[6:0], line.sda_s};
          cnt_d      = cnt_q + 4'h1;
        end
        else if (byte_done)
        begin
          if (addr_match)
          begin
            buf_d  = rx_shift_q;
            bf_d   = 1'b1;
            rw_d   = rx_shift_q[RW_BIT] && !lo_byte_q;
            nack_d = 1'b0;
            if (address_hold_en)
            begin
              ckp_d    = 1'b0;
              irq_d    = 1'b1;
              ack_time_flag_d = 1'b1;
              state_d  = ST_HOLD;
            end
            else
              state_d = ST_ACK;
          end
          else if (ten_bit_mode && lo_byte_q)
          begin
            irq_d   = 1'b1;
            ua_d    = 1'b1;
            state_d = ST_IDLE;
          end
          else
            state_d = ST_IDLE;
        end
      end
      ST_HOLD:
      begin
        if (ckp_d)
        begin
          nack_d  = ack_data_bit;
          state_d = ST_ACK;
        end
      end
      ST_ACK:
      begin
        if (line.scl_fall)
        begin
          ack_time_flag_d = 1'b0;
          cnt_d    = 4'h0;
          if (nack_q)
            state_d = ST_IDLE;
          else
          begin
            irq_d = 1'b1;
            if (rw_q)
            begin
              ckp_d   = 1'b0;
              state_d = ST_TX;
            end
            else if (ten_bit_mode && !lo_byte_q && !addr10_ok_q)
            begin
              ua_d      = 1'b1;
              lo_byte_d = 1'b1;
              state_d   = ST_ADDR;
            end
            else
            begin
              if (lo_byte_q)
              begin
                ua_d        = 1'b1;
                addr10_ok_d = 1'b1;
                lo_byte_d   = 1'b0;
              end
              else if (stretch_enable)
                ckp_d = 1'b0;
              state_d = ST_RX;
            end
          end
        end
      end
      ST_TX:
      begin
        if (line.scl_rise && tx_shift_q[7] && !line.sda_s && slave_collision_detect_en)
        begin
          bcl_d   = 1'b1;
          state_d = ST_IDLE;
        end
        else if (line.scl_fall)
        begin
          tx_shift_d = {tx_shift_q[6:0], 1'b1};
          if (cnt_q == LAST_TX_FALL)
            state_d = ST_TX_ACK;
          else
            cnt_d = cnt_q + 4'h1;
        end
      end
      ST_TX_ACK:
      begin
        if (line.scl_rise)
          ackst_d = line.sda_s;
        else if (line.scl_fall)
        begin
          irq_d = 1'b1;
          cnt_d = 4'h0;
          if (ackst_q)
            state_d = ST_IDLE;
          else
          begin
            ckp_d   = 1'b0;
            state_d = ST_TX;
          end
        end
      end
      ST_RX:
      begin
        if (line.scl_rise && cnt_q != BYTE_BITS)
        begin
          rx_shift_d = {rx_shift_q[6:0], line.sda_s};
          cnt_d      = cnt_q + 4'h1;
        end
        else if (byte_done)
        begin
          buf_d   = rx_shift_q;
          bf_d    = 1'b1;
          state_d = ST_RX_ACK;
        end
      end
      ST_RX_ACK:
      begin
        if (line.scl_fall)
        begin
          irq_d   = 1'b1;
          cnt_d   = 4'h0;
          state_d = ST_RX;
          if (stretch_enable)
            ckp_d = 1'b0;
        end
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
    // Bus conditions abort whatever byte is in flight
    if (line.start_det)
    begin
      start_d   = 1'b1;
      stop_d    = 1'b0;
      irq_d     = irq_d || start_irq_en;
      state_d   = ST_ADDR;
      cnt_d     = 4'h0;
      lo_byte_d = 1'b0;
      ack_time_flag_d  = 1'b0;
    end
    else if (line.stop_det)
    begin
      stop_d      = 1'b1;
      start_d     = 1'b0;
      state_d     = ST_IDLE;
      addr10_ok_d = 1'b0;
      ack_time_flag_d    = 1'b0;
    end
  end

  // Line drives: SCL is only grabbed once already low, so a high phase is never cut short
  always_comb
  begin
    hold_d = (!ckp_d || ua_d) && (!line.scl_s || hold_q);
    case (state_d)
      ST_ACK:  sda_n_d = nack_d;
      ST_TX:   sda_n_d = tx_shift_d[7];
      ST_RX_ACK: sda_n_d = 1'b0;
      default: sda_n_d = 1'b1;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state_q     <= ST_IDLE;
      cnt_q       <= 4'h0;
      rx_shift_q  <= BUF_RESET;
      tx_shift_q  <= BUF_RESET;
      addr_q      <= ADDR_RESET;
      buf_q       <= BUF_RESET;
      rw_q        <= 1'b0;
      start_q     <= 1'b0;
      stop_q      <= 1'b0;
      ackst_q     <= 1'b0;
      ack_time_flag_q    <= 1'b0;
      irq_q       <= 1'b0;
      bcl_q       <= 1'b0;
      bf_q        <= 1'b0;
      ua_q        <= 1'b0;
      ckp_q       <= CKP_RESET;
      nack_q      <= 1'b0;
      lo_byte_q   <= 1'b0;
      addr10_ok_q <= 1'b0;
      hold_q      <= 1'b0;
      sda_n_q     <= 1'b1;
    end
    else
    begin
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      rx_shift_q  <= rx_shift_d;
      tx_shift_q  <= tx_shift_d;
      addr_q      <= addr_d;
      buf_q       <= buf_d;
      rw_q        <= rw_d;
      start_q     <= start_d;
      stop_q      <= stop_d;
      ackst_q     <= ackst_d;
      ack_time_flag_q    <= ack_time_flag_d;
      irq_q       <= irq_d;
      bcl_q       <= bcl_d;
      bf_q        <= bf_d;
      ua_q        <= ua_d;
      ckp_q       <= ckp_d;
      nack_q      <= nack_d;
      lo_byte_q   <= lo_byte_d;
      addr10_ok_q <= addr10_ok_d;
      hold_q      <= hold_d;
      sda_n_q     <= sda_n_d;
    end
  end

  // Every output but the two constant drive values is a flop; the drive values never leave low
  assign scl_out             = LINE_LOW;
  assign sda_out             = LINE_LOW;
  assign scl_oe_n            = !hold_q;
  assign sda_oe_n            = sda_n_q;
  assign slave_address_reg   = addr_q;
  assign port_data_buffer    = buf_q;
  assign read_write_flag     = rw_q;
  assign start_flag          = start_q;
  assign stop_flag           = stop_q;
  assign ack_status_bit      = ackst_q;
  assign ack_time_flag       = ack_time_flag_q;
  assign port_interrupt_flag = irq_q;
  assign bus_collision_flag  = bcl_q;
  assign buffer_full_flag    = bf_q;
  assign update_address_flag = ua_q;
  assign clock_release_bit   = ckp_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  ack_read_a: assert property ((state_q == ST_ACK) && line.scl_fall && !nack_q && rw_q && !line.start_det
    && !line.stop_det |=> !clock_release_bit && port_interrupt_flag && state_q == ST_TX)
    else $error("read address ack did not stretch");
  tx_load_a: assert property (data_wr |=> tx_shift_q == $past(data_wdata) && buffer_full_flag)
    else $error("buffer write did not load shifter");
  tx_change_a: assert property ((state_q == ST_TX) && $past(state_q) == ST_TX && $changed(sda_oe_n)
    |-> $past(line.scl_fall) || $past(data_wr))
    else $error("data changed away from a falling clock");
  ack_latch_a: assert property ((state_q == ST_TX_ACK) && line.scl_rise && !line.start_det && !line.stop_det
    |=> ack_status_bit == $past(line.sda_s))
    else $error("master response not latched");
  nack_idle_a: assert property ((state_q == ST_TX_ACK) && line.scl_fall && ack_status_bit && !line.start_det
    |=> state_q == ST_IDLE && port_interrupt_flag ##1 scl_oe_n)
    else $error("not-ack did not end the transfer");
  collision_a: assert property ((state_q == ST_TX) && line.scl_rise && tx_shift_q[7] && !line.sda_s
    && slave_collision_detect_en && !line.start_det && !line.stop_det |=> bus_collision_flag && state_q == ST_IDLE)
    else $error("collision not flagged");
  start_irq_a: assert property (line.start_det && start_irq_en |=> start_flag && port_interrupt_flag
    && state_q == ST_ADDR)
    else $error("start not reported");
  addr_hold_a: assert property ((state_q == ST_ADDR) && byte_done && addr_match && address_hold_en
    && !line.start_det && !line.stop_det |=> !clock_release_bit && port_interrupt_flag && ack_time_flag)
    else $error("address hold did not stretch");
  addr_write_a: assert property (addr_wr && !line.scl_fall && !line.start_det
    |=> !update_address_flag)
    else $error("address write left update flag set");
  ack_release_a: assert property ((state_q == ST_TX_ACK) && $past(state_q) == ST_TX_ACK |-> sda_oe_n)
    else $error("data line driven in master ack slot");
endmodule
`default_nettype wire

// ### sim/i2c_master_model.sv
// Behavioural bus master that times its bits from the link clock
`default_nettype none
module i2c_master_model (
  input  wire logic link_clk, // Bit-timing clock, 15 ns
  input  wire logic scl_oe_n, // Slave pulls the clock line low
  input  wire logic sda_oe_n, // Slave pulls the data line low
  output logic      scl_in,   // Resolved clock line
  output logic      sda_in    // Resolved data line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic scl_m = 1'b1;
  logic sda_m = 1'b1;
  // Open-drain lines with pull-ups, so a released line reads high
  assign scl_in = scl_m & scl_oe_n;
  assign sda_in = sda_m & sda_oe_n;
  // Quarter bit of 120 ns keeps the low phase well above the minimum
  task automatic q();
    repeat (8) @(posedge link_clk);
  endtask
  // Release the clock and honour any stretching, but never forever
  task automatic hi();
    int n;
    n = 0;
    scl_m = 1'b1;
    while (!scl_in && n < 50000)
    begin
      @(posedge link_clk);
      n++;
    end
    q();
  endtask
  // Data moves a quarter bit after the fall so it never looks like a Start
  task automatic bit_io(input logic b, output logic s);
    q();
    sda_m = b;
    q();
    hi();
    s = sda_in;
    q();
    scl_m = 1'b0;
  endtask
  task automatic start();
    sda_m = 1'b1;
    q();
    hi();
    sda_m = 1'b0;
    q();
    scl_m = 1'b0;
  endtask
  task automatic stop();
    q();
    sda_m = 1'b0;
    q();
    hi();
    sda_m = 1'b1;
    q();
  endtask
  // Eight bits MSB first, then the acknowledge bit
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] r, output logic ra);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r[i]);
    bit_io(a, ra);
  endtask
endmodule
`default_nettype wire

// ### sim/i2c_slave_tx_and_ten_bit_rx_tb.sv
// Self-checking bench: read transfers, collision, address hold, 10-bit reception
`default_nettype none
module i2c_slave_tx_and_ten_bit_rx_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, link_clk, rst_n, scl_in, sda_in, scl_oe_n, sda_oe_n, ra;
  logic ten_bit_mode, address_hold_en, stretch_enable, slave_collision_detect_en, start_irq_en, ack_data_bit;
  logic addr_wr, data_wr, data_rd, clock_release_set, irq_clear, collision_clear;
  logic [7:0] addr_wdata, data_wdata, slave_address_reg, port_data_buffer, r, d, hb;
  logic read_write_flag, start_flag, stop_flag, ack_status_bit, ack_time_flag, port_interrupt_flag;
  logic bus_collision_flag, buffer_full_flag, update_address_flag, clock_release_bit;
  logic [6:0] a;
  logic [31:0] x;
  int fails = 0, samples_checked = 0, cyc = 0;
  i2c_slave i2c_slave_i (.core_clk, .rst_n, .scl_in, .scl_out(), .scl_oe_n, .sda_in, .sda_out(), .sda_oe_n,
    .ten_bit_mode, .address_hold_en, .stretch_enable, .slave_collision_detect_en, .start_irq_en, .ack_data_bit,
    .addr_wr, .addr_wdata, .data_wr, .data_wdata, .data_rd, .clock_release_set, .irq_clear, .collision_clear,
    .slave_address_reg, .port_data_buffer, .read_write_flag, .start_flag, .stop_flag, .ack_status_bit,
    .ack_time_flag, .port_interrupt_flag, .bus_collision_flag, .buffer_full_flag, .update_address_flag,
    .clock_release_bit);
  i2c_master_model i2c_master_model_i (.link_clk, .scl_oe_n, .sda_oe_n, .scl_in, .sda_in);
  // Two unrelated clocks
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial
  begin
    link_clk = 1'b0;
    #3.3;
    forever #7.5 link_clk = ~link_clk;
  end
  function automatic logic [31:0] xs();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // One-cycle firmware pulse: 0 addr, 1 data, 2 read, 3 release, 4 irq clear, 5 collision clear
  task automatic pw(input int k, input logic [7:0] v);
    @(negedge core_clk);
    addr_wdata = v;
    data_wdata = v;
    {collision_clear, irq_clear, clock_release_set, data_rd, data_wr, addr_wr} = 6'h01 << k;
    @(negedge core_clk);
    {collision_clear, irq_clear, clock_release_set, data_rd, data_wr, addr_wr} = 6'h00;
  endtask
  // Lets the synchronisers catch up with the last line change
  task automatic st();
    repeat (10) @(negedge core_clk);
  endtask
  task automatic wt();
    int n;
    n = 0;
    while (clock_release_bit !== 1'b0 && n < 5000)
    begin
      @(negedge core_clk);
      n++;
    end
    st();
  endtask
  task automatic sb();
    i2c_master_model_i.start();
    st();
    chk("start_flag", {start_flag, port_interrupt_flag}, 8'h03);
    pw(4, 8'h00);
    pw(2, 8'h00);
  endtask
  task automatic ad(input logic [7:0] b);
    sb();
    i2c_master_model_i.xfer(b, 1'b1, r, ra);
    st();
  endtask
  task automatic rb(input logic last);
    pw(4, 8'h00);
    pw(2, 8'h00);
    d = 8'(xs());
    pw(1, d);
    chk("buffer_full", buffer_full_flag, 8'h01);
    pw(3, 8'h00);
    i2c_master_model_i.xfer(8'hFF, last, r, ra);
    st();
    chk("tx_data", r, d);
    chk("ack_status", ack_status_bit, last);
    chk("tx_stretch", {clock_release_bit, scl_oe_n}, {6'h00, last, last});
    chk("tx_irq", port_interrupt_flag, 8'h01);
  endtask
  // Cuts a hang short; the planned run needs well under this
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      fails++;
      print_verdict();
    end
  end
  initial
  begin
    x = 32'h15;
    rst_n = 1'b0;
    {ten_bit_mode, address_hold_en, stretch_enable, ack_data_bit, addr_wdata, data_wdata} = 20'h00000;
    {slave_collision_detect_en, start_irq_en} = 2'h3;
    {collision_clear, irq_clear, clock_release_set, data_rd, data_wr, addr_wr} = 6'h00;
    repeat (12) @(negedge core_clk);
    rst_n = 1'b1;
    st();
    chk("reset_state", {scl_oe_n, sda_oe_n, clock_release_bit, port_interrupt_flag, bus_collision_flag,
      buffer_full_flag, update_address_flag}, 8'h70);
    a = 7'(xs()) | 7'h01;
    pw(0, {a, 1'b0});
    // Read address then two bytes, the last answered with not-acknowledge
    ad({a, 1'b1});
    chk("addr_ack", {ra, read_write_flag, port_interrupt_flag}, 8'h03);
    chk("addr_buffer", port_data_buffer, {a, 1'b1});
    chk("addr_stretch", {clock_release_bit, scl_oe_n}, 8'h00);
    rb(1'b0);
    rb(1'b1);
    i2c_master_model_i.stop();
    // Master holds data low while the slave sends ones
    ad({a, 1'b1});
    pw(1, 8'hFF);
    pw(3, 8'h00);
    i2c_master_model_i.xfer(8'h00, 1'b1, r, ra);
    st();
    chk("collision", {bus_collision_flag, sda_oe_n, scl_oe_n}, 8'h07);
    pw(5, 8'h00);
    i2c_master_model_i.stop();
    // Address hold: firmware refuses first, then accepts and sends one byte
    @(negedge core_clk);
    address_hold_en = 1'b1;
    for (int v = 1; v >= 0; v--)
    begin
      sb();
      fork
        i2c_master_model_i.xfer({a, 1'b1}, 1'b1, r, ra);
        begin
          wt();
          chk("hold_irq", {port_interrupt_flag, ack_time_flag, scl_oe_n}, 8'h06);
          pw(4, 8'h00);
          ack_data_bit = 1'(v);
          pw(3, 8'h00);
        end
      join
      st();
      chk("hold_ack", ra, 8'(v));
      if (v == 0)
      begin
        chk("hold_rd", {clock_release_bit, port_interrupt_flag}, 8'h01);
        rb(1'b1);
      end
      i2c_master_model_i.stop();
    end
    @(negedge core_clk);
    address_hold_en = 1'b0;
    // Ten-bit: mismatching low byte first, then a match and one data byte
    {ten_bit_mode, stretch_enable} = 2'h3;
    hb = {5'h1E, 2'(xs()), 1'b0};
    for (int m = 1; m >= 0; m--)
    begin
      d = 8'(xs());
      pw(0, hb);
      ad(hb);
      chk("hi_ack", {ra, update_address_flag, scl_oe_n}, 8'h02);
      pw(4, 8'h00);
      pw(2, 8'h00);
      pw(0, d);
      st();
      chk("ua_clear", {update_address_flag, scl_oe_n}, 8'h01);
      // A mismatching low byte is stretched before its ninth clock, so firmware must act meanwhile
      fork
        i2c_master_model_i.xfer(d ^ 8'(m), 1'b1, r, ra);
        begin
          wait (update_address_flag === 1'b1);
          st();
          chk("lo_flags", {port_interrupt_flag, update_address_flag, buffer_full_flag}, {5'h00, 3'h6 | 3'(m == 0)});
          pw(0, hb);
        end
      join
      st();
      chk("lo_ack", ra, 8'(m));
      if (m == 0)
      begin
        pw(4, 8'h00);
        i2c_master_model_i.xfer(~d, 1'b1, r, ra);
        st();
        chk("rx_data", port_data_buffer, ~d);
        chk("rx_stretch", {port_interrupt_flag, clock_release_bit}, 8'h02);
        pw(3, 8'h00);
      end
      i2c_master_model_i.stop();
    end
    print_verdict();
  end
endmodule
`default_nettype wire
